// ==== verif/spi_slave_model.sv ====
// Behavioural SPI slave that answers with a pseudo-random byte stream
`timescale 1ns/1ps
module spi_slave_model (
	input  wire logic  sys_clk,    // System clock
	input  wire logic  rst,        // Model reset
	input  wire logic  sck,        // Transfer clock
	input  wire logic  mosi,       // Data from master
	input  wire logic  cpol,       // Idle clock level
	input  wire logic  cpha,       // Clock phase
	output logic       miso,       // Data to master
	output logic       frame_done, // Eight bits seen
	output logic [7:0] got_byte,   // Arrival order, first bit at bit 7
	output logic [7:0] sent_byte   // Sent order, first bit at bit 7
);
	logic       sck_q;
	logic [7:0] tx_sr;
	logic [7:0] rx_sr;
	logic [2:0] nbits;
	logic       lead;
	logic       trail;
	logic       smp;
	logic       stp;
	assign lead  = (sck !== sck_q) && (sck_q === cpol);
	assign trail = (sck !== sck_q) && (sck === cpol);
	assign smp   = cpha ? trail : lead;
	assign stp   = cpha ? lead : trail;
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nxt
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sck_q <= sck;
			tx_sr <= 8'hA7;
			rx_sr <= 8'h00;
			nbits <= 3'h0;
			miso <= 1'b1;
			frame_done <= 1'b0;
			got_byte <= 8'h00;
			sent_byte <= 8'h00;
		end else begin
			sck_q <= sck;
			frame_done <= 1'b0;
			if (smp) begin
				rx_sr <= {rx_sr[6:0], mosi};
				nbits <= nbits + 3'h1;
				if (nbits == 3'h7) begin
					frame_done <= 1'b1;
					got_byte <= {rx_sr[6:0], mosi};
					sent_byte <= tx_sr;
					tx_sr <= nxt(tx_sr);
					// With phase 1, the released line shows the inverse of its last level
					if (cpha) begin
						miso <= ~miso;
					end
				end
			end
			if (stp) begin
				miso <= tx_sr[3'h7 - nbits];
			end
		end
	end
endmodule : spi_slave_model

// ==== verif/usart_master_spi_bench.sv ====
// Testbench of the master SPI mode against a slave model and byte queues
`timescale 1ns/1ps
module usart_master_spi_bench;
	import mspi_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [1:0]  mode_select = 2'h2;
	logic        transmit_enable = 1'b1;
	logic        receive_enable = 1'b1;
	divisor_type baud_divisor = 12'h000;
	logic        clock_polarity_sel = 1'b0;
	logic        clock_phase_sel = 1'b0;
	logic        bit_order_sel = 1'b0;
	logic        data_wr = 1'b0;
	byte_type    data_wr_byte = 8'h00;
	logic        data_rd = 1'b0;
	logic        transmit_done_clear = 1'b0;
	logic        slv_rst = 1'b1;
	byte_type    rd_data, got_b, sent_b;
	logic        receive_done_flag, transmit_done_flag, tx_buffer_empty_flag, f_done;
	logic        serial_clock_pin, serial_out_pin, serial_out_own, serial_in_pin, serial_in_own;
	int          mismatches = 0;
	int          n_compared = 0;
	int          dv = 0;
	byte_type    exp_q[$], got_q[$], rxm[$];

	always #12.5 sys_clk = ~sys_clk;

	usart_master_spi u_dut (.sys_clk(sys_clk), .rst(rst), .mode_select(mode_select),
		.transmit_enable(transmit_enable), .receive_enable(receive_enable), .baud_divisor(baud_divisor),
		.clock_polarity_sel(clock_polarity_sel), .clock_phase_sel(clock_phase_sel),
		.bit_order_sel(bit_order_sel), .data_wr(data_wr), .data_wr_byte(data_wr_byte), .data_rd(data_rd),
		.transmit_done_clear(transmit_done_clear), .rd_data(rd_data), .receive_done_flag(receive_done_flag),
		.transmit_done_flag(transmit_done_flag), .tx_buffer_empty_flag(tx_buffer_empty_flag),
		.serial_clock_pin(serial_clock_pin), .serial_out_pin(serial_out_pin),
		.serial_out_own(serial_out_own), .serial_in_pin(serial_in_pin), .serial_in_own(serial_in_own));

	spi_slave_model u_slave (.sys_clk(sys_clk), .rst(slv_rst), .sck(serial_clock_pin),
		.mosi(serial_out_pin), .cpol(clock_polarity_sel), .cpha(clock_phase_sel), .miso(serial_in_pin),
		.frame_done(f_done), .got_byte(got_b), .sent_byte(sent_b));

	function automatic byte_type rev(input byte_type b);
		for (int i = 0; i < 8; i++) begin
			rev[i] = b[7-i];
		end
	endfunction : rev

	// Reference receive buffer of two bytes, later arrivals dropped
	always @(posedge sys_clk) begin
		if (f_done === 1'b1) begin
			got_q.push_back(got_b);
			if (receive_enable && rxm.size() < 2) begin
				rxm.push_back(bit_order_sel ? rev(sent_b) : sent_b);
			end
		end
	end

	task automatic finish_test;
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic check(input byte_type got, input byte_type exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic send(input byte_type b);
		int t;
		t = 0;
		@(negedge sys_clk);
		while (tx_buffer_empty_flag !== 1'b1 && t < 5000) begin
			@(negedge sys_clk);
			t++;
		end
		@(posedge sys_clk);
		data_wr <= 1'b1;
		data_wr_byte <= b;
		transmit_done_clear <= 1'b1;
		@(posedge sys_clk);
		data_wr <= 1'b0;
		transmit_done_clear <= 1'b0;
		exp_q.push_back(bit_order_sel ? rev(b) : b);
	endtask : send

	task automatic edges(input int n);
		logic p;
		int   c;
		c = 0;
		@(negedge sys_clk);
		p = serial_clock_pin;
		while (serial_clock_pin === p && c < 20000) begin
			@(negedge sys_clk);
			c++;
		end
		for (int i = 1; i < n; i++) begin
			p = serial_clock_pin;
			c = 0;
			while (serial_clock_pin === p && c < 9000) begin
				@(negedge sys_clk);
				c++;
			end
			check(8'(c), 8'(dv + 1));
			if (i < n - 1) begin
				check(8'(transmit_done_flag), 8'h00);
			end
		end
	endtask : edges

	task automatic wait_done;
		int t;
		t = 0;
		while (transmit_done_flag !== 1'b1 && t < 2000) begin
			@(negedge sys_clk);
			t++;
		end
		check(8'(transmit_done_flag), 8'h01);
		@(negedge sys_clk);
		check(8'(serial_out_pin), 8'h01);
	endtask : wait_done

	task automatic cmp_frames;
		repeat (4) @(negedge sys_clk);
		check(8'(got_q.size()), 8'(exp_q.size()));
		while (got_q.size() > 0 && exp_q.size() > 0) begin
			check(got_q.pop_front(), exp_q.pop_front());
		end
		exp_q.delete();
		got_q.delete();
	endtask : cmp_frames

	task automatic xfer(input int n);
		fork
			begin
				repeat (n) send(8'($urandom));
			end
			edges(16 * n);
		join
		wait_done();
		cmp_frames();
	endtask : xfer

	task automatic rd_all;
		for (int k = 0; k < 3; k++) begin
			@(negedge sys_clk);
			check(8'(receive_done_flag), 8'(rxm.size() != 0));
			if (rxm.size() != 0) begin
				check(rd_data, rxm.pop_front());
				@(posedge sys_clk);
				data_rd <= 1'b1;
				@(posedge sys_clk);
				data_rd <= 1'b0;
			end
		end
	endtask : rd_all

	task automatic cfg(input logic pol, input logic pha, input logic lsb, input int d, input logic rx);
		@(posedge sys_clk);
		mode_select <= 2'h3;
		clock_polarity_sel <= pol;
		clock_phase_sel <= pha;
		bit_order_sel <= lsb;
		baud_divisor <= 12'(d);
		receive_enable <= rx;
		slv_rst <= 1'b1;
		dv = d;
		if (!rx) begin
			rxm.delete();
		end
		repeat (3) @(posedge sys_clk);
		slv_rst <= 1'b0;
		@(negedge sys_clk);
		check(8'(serial_clock_pin), 8'(pol));
	endtask : cfg

	initial begin
		repeat (40000) @(posedge sys_clk);
		mismatches++;
		finish_test();
	end

	initial begin
		dv = $urandom(32'h35DD6D27);
		dv = 0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check(8'(tx_buffer_empty_flag), 8'h01);
		check(8'(receive_done_flag), 8'h00);
		check(8'(serial_out_pin), 8'h01);
		check(8'(serial_in_own), 8'h00);
		send(8'h3C);
		exp_q.delete();
		repeat (40) @(negedge sys_clk);
		check(8'(tx_buffer_empty_flag), 8'h01);
		check(8'(got_q.size()), 8'h00);
		// divisor still zero as the mode goes live
		cfg(1'b0, 1'b0, 1'b0, 0, 1'b0);
		check(8'(serial_out_own), 8'h01);
		xfer(2);
		rd_all();
		for (int m = 0; m < 8; m++) begin
			cfg(m[0], m[1], m[2], 3 + int'($urandom % 3), 1'b1);
			check(8'(serial_in_own), 8'h01);
			xfer(1);
			rd_all();
		end
		xfer(4);
		rd_all();
		xfer(1);
		cfg(1'b1, 1'b1, 1'b1, dv, 1'b0);
		check(8'(receive_done_flag), 8'h00);
		fork
			begin
				send(8'($urandom));
				@(posedge sys_clk);
				transmit_enable <= 1'b0;
				repeat (3) @(negedge sys_clk);
				check(8'(serial_out_own), 8'h01);
			end
			edges(16);
		join
		wait_done();
		cmp_frames();
		check(8'(serial_out_own), 8'h00);
		finish_test();
	end
endmodule : usart_master_spi_bench

// ==== verilog/baud_gen.sv ====
// Half-bit tick generator: one pulse every divisor+1 cycles while running
`timescale 1ns/1ps
`include "mspi_defines.svh"
module baud_gen #(
	parameter int WIDTH = `MSPI_BAUD_W
) (
	input  wire logic             sys_clk, // System clock
	input  wire logic             rst,     // Async reset, active high
	input  wire logic             run,     // Count while high, restart when low
	input  wire logic [WIDTH-1:0] divisor, // Cycles per half period minus one
	output logic                  tick     // Half-period pulse
);
	logic [WIDTH-1:0] cnt_q;

	if (WIDTH < 1) begin : g_chk
		$error("baud_gen: WIDTH must be at least 1");
	end

	assign tick = run && (cnt_q == divisor);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (!run || tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule : baud_gen

// ==== verilog/mspi_defines.svh ====
// Constants for the master SPI mode of the serial unit
`ifndef MSPI_DEFINES_SVH
`define MSPI_DEFINES_SVH

`define MSPI_MODE_MASTER 2'h3
`define MSPI_FRAME_BITS 8
`define MSPI_BIT_IDX_W 3
`define MSPI_BIT_IDX_LAST 3'h7
`define MSPI_BIT_IDX_FIRST 3'h0
`define MSPI_BAUD_W 12
`define MSPI_DIV_RESET 12'h000
`define MSPI_LINE_IDLE 1'b1
`define MSPI_TXE_RESET 1'b1
`define MSPI_BUF_DEPTH 2

`endif

// ==== verilog/mspi_pkg.sv ====
// Types shared by the master SPI mode modules
package mspi_pkg;
	typedef logic [7:0] byte_type;
	typedef logic [11:0] divisor_type;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SHIFT = 2'h1
	} shift_state_type;
endpackage : mspi_pkg

// ==== verilog/stream_if.sv ====
// Valid/ready byte stream into and out of the receive buffer (shift engine side and read side)
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 8);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

// ==== verilog/two_entry_buf.sv ====
// Two-entry flip-flop buffer with valid/ready on both sides and a flush
`timescale 1ns/1ps
`include "mspi_defines.svh"
module two_entry_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `MSPI_BUF_DEPTH
) (
	input  wire logic sys_clk, // System clock
	input  wire logic rst,     // Async reset, active high
	input  wire logic flush,   // Drop all entries
	stream_if.snk     in_s,    // Filling side
	stream_if.src     out_s    // Draining side
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic             wr_ptr_q;
	logic             rd_ptr_q;
	logic [1:0]       cnt_q;
	logic             push;
	logic             pop;

	if (DEPTH != 2) begin : g_chk
		$error("two_entry_buf: DEPTH must be 2");
	end

	assign in_s.ready  = (cnt_q != 2'h2);
	assign out_s.valid = (cnt_q != 2'h0);
	assign out_s.data  = mem_q[rd_ptr_q];
	assign push        = in_s.valid && in_s.ready && !flush;
	assign pop         = out_s.valid && out_s.ready && !flush;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (push) begin
			mem_q[wr_ptr_q] <= in_s.data;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q    <= 2'h0;
		end else if (flush) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			wr_ptr_q <= wr_ptr_q ^ push;
			rd_ptr_q <= rd_ptr_q ^ pop;
			cnt_q    <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : two_entry_buf

// ==== verilog/usart_master_spi.sv ====
// Master-only SPI mode of the serial unit: transmit buffer, shift engine, receive buffer
`timescale 1ns/1ps
`include "mspi_defines.svh"
module usart_master_spi #(
	parameter int BAUD_W = `MSPI_BAUD_W
) (
	input  wire logic                sys_clk,              // 40 MHz system clock
	input  wire logic                rst,                  // Async reset, active high
	input  wire logic [1:0]          mode_select,          // Mode field, 2'h3 = master SPI
	input  wire logic                transmit_enable,      // Transmitter enable
	input  wire logic                receive_enable,       // Receiver enable
	input  wire mspi_pkg::divisor_type baud_divisor,       // Baud divisor 0-4095
	input  wire logic                clock_polarity_sel,   // Idle clock level
	input  wire logic                clock_phase_sel,      // 0 sample on leading edge
	input  wire logic                bit_order_sel,        // 1 = LSB first
	input  wire logic                data_wr,              // Data window write strobe
	input  wire mspi_pkg::byte_type  data_wr_byte,         // Byte written
	input  wire logic                data_rd,              // Data window read strobe
	input  wire logic                transmit_done_clear,  // Write-one or interrupt acknowledge
	output mspi_pkg::byte_type       rd_data,              // Oldest received byte
	output logic                     receive_done_flag,    // Unread data present
	output logic                     transmit_done_flag,   // All data shifted out
	output logic                     tx_buffer_empty_flag, // Transmit buffer writable
	output logic                     serial_clock_pin,     // Transfer clock out
	output logic                     serial_out_pin,       // Serial data out
	output logic                     serial_out_own,       // Data out pin taken from port logic
	input  wire logic                serial_in_pin,        // Serial data in, asynchronous
	output logic                     serial_in_own         // Data in pin taken from port logic
);
	import mspi_pkg::*;

	if (BAUD_W != `MSPI_BAUD_W) begin : g_chk
		$error("usart_master_spi: BAUD_W must match divisor width");
	end

	// ==========================================================
	// Mode and enables
	logic                       master_spi_mode;
	logic                       tx_on_q;
	logic                       active;
	shift_state_type            state_q;
	logic                       tx_full_q;
	byte_type                   tx_buf_q;
	byte_type                   sh_q;
	byte_type                   rx_sh_q;
	logic                       out_q;
	logic                       sck_q;
	logic                       lead_q;
	logic [`MSPI_BIT_IDX_W-1:0] bit_cnt_q;
	logic                       txc_q;
	logic                       rx_push_q;
	logic                       rx_s1_q;
	logic                       rx_s2_q;
	logic                       tick;
	logic                       wr_take;
	logic                       load;
	logic                       frame_end;
	logic                       sample_edge;
	logic                       rx_flush;
	byte_type                   sh_next;

	stream_if #(.WIDTH(8)) rx_in ();
	stream_if #(.WIDTH(8)) rx_out ();

	assign master_spi_mode = (mode_select == `MSPI_MODE_MASTER);
	assign active          = master_spi_mode && tx_on_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_on_q <= 1'b0;
		end else if (transmit_enable && master_spi_mode) begin
			tx_on_q <= 1'b1;
		end else if (state_q == ST_IDLE && !tx_full_q) begin
			tx_on_q <= 1'b0;
		end
	end

	assign serial_out_own = active;
	assign serial_in_own  = master_spi_mode && receive_enable;

	// ==========================================================
	// Transmit buffer
	// write starts transfer
	assign wr_take = data_wr && active && !tx_full_q;
	assign load    = active && tx_full_q && (state_q == ST_IDLE || frame_end);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_full_q <= 1'b0;
			tx_buf_q  <= '0;
		end else if (wr_take) begin
			tx_full_q <= 1'b1;
			tx_buf_q  <= data_wr_byte;
		end else if (load) begin
			tx_full_q <= 1'b0;
		end
	end

	assign tx_buffer_empty_flag = !tx_full_q;

	// ==========================================================
	// Baud generator
	// internal clock only
	baud_gen #(.WIDTH(BAUD_W)) u_baud (
		.sys_clk (sys_clk),
		.rst     (rst),
		.run     (active && state_q == ST_SHIFT),
		.divisor (baud_divisor),
		.tick    (tick)
	);

	// ==========================================================
	// Shift engine sequencing
	// one common transfer controller
	assign frame_end = tick && lead_q && (bit_cnt_q == `MSPI_BIT_IDX_LAST);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else if (!master_spi_mode) begin
			state_q <= ST_IDLE;
		end else if (load) begin
			state_q <= ST_SHIFT;
		end else if (frame_end) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_q <= ST_IDLE;
				end
				ST_SHIFT: begin
					state_q <= ST_SHIFT;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lead_q    <= 1'b0;
			bit_cnt_q <= `MSPI_BIT_IDX_FIRST;
		end else if (load) begin
			lead_q    <= 1'b0;
			bit_cnt_q <= `MSPI_BIT_IDX_FIRST;
		end else if (tick) begin
			lead_q    <= !lead_q;
			bit_cnt_q <= bit_cnt_q + {2'h0, lead_q};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sck_q <= 1'b0;
		end else if (state_q == ST_IDLE || !master_spi_mode) begin
			sck_q <= clock_polarity_sel;
		end else if (tick) begin
			sck_q <= lead_q ? clock_polarity_sel : !clock_polarity_sel;
		end
	end
	assign serial_clock_pin = sck_q;

	// ==========================================================
	// Transmit shifter
	// one bit order for both
	assign sh_next = bit_order_sel ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sh_q  <= '0;
			out_q <= `MSPI_LINE_IDLE;
		end else if (load) begin
			sh_q  <= tx_buf_q;
			if (!clock_phase_sel) begin
				out_q <= bit_order_sel ? tx_buf_q[0] : tx_buf_q[7];
			end
		end else if (state_q == ST_IDLE || (frame_end && !clock_phase_sel)) begin
			// line high, phase 0 after last sample
			out_q <= `MSPI_LINE_IDLE;
		end else if (tick && !lead_q) begin
			if (clock_phase_sel) begin
				out_q <= bit_order_sel ? sh_q[0] : sh_q[7];
			end
		end else if (tick && lead_q) begin
			sh_q <= sh_next;
			if (!clock_phase_sel) begin
				out_q <= bit_order_sel ? sh_next[0] : sh_next[7];
			end
		end
	end
	assign serial_out_pin = out_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txc_q <= 1'b0;
		end else if (frame_end && !tx_full_q) begin
			txc_q <= 1'b1;
		end else if (transmit_done_clear) begin
			txc_q <= 1'b0;
		end
	end
	assign transmit_done_flag = txc_q;

	// ==========================================================
	// Receive path
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_s1_q <= 1'b0;
			rx_s2_q <= 1'b0;
		end else begin
			rx_s1_q <= serial_in_pin;
			rx_s2_q <= rx_s1_q;
		end
	end

	assign sample_edge = tick && (lead_q == clock_phase_sel);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_sh_q <= '0;
		end else if (sample_edge) begin
			rx_sh_q <= bit_order_sel ? {rx_s2_q, rx_sh_q[7:1]} : {rx_sh_q[6:0], rx_s2_q};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_push_q <= 1'b0;
		end else begin
			rx_push_q <= frame_end && receive_enable;
		end
	end

	assign rx_in.valid  = rx_push_q;
	assign rx_in.data   = rx_sh_q;
	assign rx_out.ready = data_rd;
	assign rx_flush     = !receive_enable || !master_spi_mode;

	two_entry_buf #(.WIDTH(8), .DEPTH(`MSPI_BUF_DEPTH)) u_rx_buf (
		.sys_clk (sys_clk),
		.rst     (rst),
		.flush   (rx_flush),
		.in_s    (rx_in.snk),
		.out_s   (rx_out.src)
	);

	assign rd_data           = rx_out.data;
	assign receive_done_flag = rx_out.valid;

	// ==========================================================
	// Checks
	sequence s_idle_two;
		(state_q == ST_IDLE)[*2];
	endsequence

	sequence s_queued_end;
		frame_end && tx_full_q && active;
	endsequence

	AST_MODE_OFF_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
		!master_spi_mode |=> state_q == ST_IDLE) else $error("engine runs outside SPI mode");
	AST_SCK_IDLE_LEVEL: assert property (@(posedge sys_clk) disable iff (rst)
		s_idle_two ##0 $stable(clock_polarity_sel) |-> serial_clock_pin == clock_polarity_sel)
		else $error("idle clock not at polarity level");
	AST_OUT_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
		s_idle_two |-> serial_out_pin) else $error("data line not high while idle");
	AST_FRAME_EIGHT: assert property (@(posedge sys_clk) disable iff (rst)
		load |=> state_q == ST_SHIFT && bit_cnt_q == `MSPI_BIT_IDX_FIRST && !lead_q)
		else $error("frame did not restart at first bit");
	AST_NO_GAP: assert property (@(posedge sys_clk) disable iff (rst)
		s_queued_end |=> state_q == ST_SHIFT && !tx_full_q && !transmit_done_flag)
		else $error("queued frame did not follow directly");
	AST_TXC_SET: assert property (@(posedge sys_clk) disable iff (rst)
		frame_end && !tx_full_q |=> transmit_done_flag) else $error("transmit done not set");
	AST_TXE_RESET: assert property (@(posedge sys_clk)
		$fell(rst) |-> tx_buffer_empty_flag) else $error("buffer empty flag clear after reset");
	AST_RX_DROP: assert property (@(posedge sys_clk) disable iff (rst)
		rx_in.valid && !rx_in.ready && !data_rd && !rx_flush |=> $stable(rd_data) && receive_done_flag)
		else $error("overflow disturbed stored bytes");
	AST_RX_FLUSH: assert property (@(posedge sys_clk) disable iff (rst)
		!receive_enable |=> !receive_done_flag) else $error("receive buffer not flushed");
	AST_DISABLE_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == ST_SHIFT && master_spi_mode |=> serial_out_own)
		else $error("transmitter released mid-frame");
	AST_BAUD_FAST: assert property (@(posedge sys_clk) disable iff (rst)
		tick && baud_divisor == '0 && state_q == ST_SHIFT && !frame_end && $stable(baud_divisor)
		|=> tick) else $error("divisor zero did not tick every cycle");
endmodule : usart_master_spi
